/* logic/dcd_pkg.sv */
`default_nettype none
package dcd_pkg;

    // address, bank and data geometry of the sixteen-bit part
    localparam int ADDR_W    = 13;
    localparam int BA_W      = 2;
    localparam int NUM_BANKS = 4;
    localparam int COL_W     = 10;
    localparam int AP_BIT    = 10;
    localparam int DQ_W      = 16;
    localparam int DM_W      = 2;
    localparam int LANE_W    = 8;

    // {ras_n, cas_n, we_n} with chip select low, per the published standard
    localparam logic [2:0] PIN_LMR = 3'h0;
    localparam logic [2:0] PIN_REF = 3'h1;
    localparam logic [2:0] PIN_PRE = 3'h2;
    localparam logic [2:0] PIN_ACT = 3'h3;
    localparam logic [2:0] PIN_WR  = 3'h4;
    localparam logic [2:0] PIN_RD  = 3'h5;
    localparam logic [2:0] PIN_NOP = 3'h7;

    typedef enum logic [2:0] {
        CMD_DESEL = 3'h0,
        CMD_NOP   = 3'h1,
        CMD_ACT   = 3'h2,
        CMD_RD    = 3'h3,
        CMD_WR    = 3'h4,
        CMD_PRE   = 3'h5,
        CMD_REF   = 3'h6,
        CMD_LMR   = 3'h7
    } dcd_cmd_e;

    typedef enum logic [1:0] {
        PWR_ON   = 2'h0,
        PWR_PPD  = 2'h1,
        PWR_APD  = 2'h2,
        PWR_SREF = 2'h3
    } dcd_pwr_e;

    typedef enum logic [1:0] {
        MR_MAIN = 2'h0,
        MR_EXT1 = 2'h1,
        MR_EXT2 = 2'h2,
        MR_EXT3 = 2'h3
    } dcd_mr_e;

    typedef struct packed {
        dcd_cmd_e               cmd;
        logic [BA_W-1:0]        ba;
        logic [ADDR_W-1:0]      addr;
        logic [NUM_BANKS-1:0]   open;
    } dcd_event_s;

endpackage : dcd_pkg
`default_nettype wire

/* logic/dcd_beat_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface dcd_beat_if #(
    parameter int DQ_W = 16,
    parameter int DM_W = 2
);
    logic [DQ_W-1:0] rise_data;
    logic [DQ_W-1:0] fall_data;
    logic [DM_W-1:0] rise_be;
    logic [DM_W-1:0] fall_be;

    modport src (output rise_data, output fall_data, output rise_be, output fall_be);
    modport snk (input rise_data, input fall_data, input rise_be, input fall_be);
endinterface : dcd_beat_if
`default_nettype wire

/* logic/dcd_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module dcd_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,    // destination clock
    input  wire logic [W-1:0] i_d,      // level from another domain
    output var  logic [W-1:0] o_q       // synchronised level
);
    logic [W-1:0] meta_reg;

    initial begin
        if (W < 1) $error("dcd_sync2: W must be at least 1");
    end

    // meta_reg feeds only o_q
    always_ff @(posedge i_clk) begin
        meta_reg <= i_d;
        o_q      <= meta_reg;
    end
endmodule : dcd_sync2
`default_nettype wire

/* logic/dcd_mask_cap.sv */
`timescale 1ns/10ps
`default_nettype none
module dcd_mask_cap #(
    parameter int DQ_W   = dcd_pkg::DQ_W,
    parameter int DM_W   = dcd_pkg::DM_W,
    parameter int LANE_W = dcd_pkg::LANE_W
) (
    input  wire logic            i_dqs,      // write data strobe
    input  wire logic            i_rst,      // reset, asserted asynchronously to the strobe
    input  wire logic [DQ_W-1:0] i_dq,       // write data
    input  wire logic [DM_W-1:0] i_dm,       // per-lane mask, high masks the lane
    dcd_beat_if.src              beat        // rise/fall beat pair with lane enables
);
    logic [DQ_W-1:0] rise_dq_reg;
    logic [DM_W-1:0] rise_dm_reg;

    initial begin
        if (DQ_W != DM_W * LANE_W) $error("dcd_mask_cap: DQ_W must equal DM_W * LANE_W");
    end

    // the strobe only toggles during writes, so reset cannot wait for its edges
    always_ff @(posedge i_dqs or posedge i_rst) begin
        if (i_rst) begin
            rise_dq_reg <= '0;
            rise_dm_reg <= '0;
        end else begin
            rise_dq_reg <= i_dq;
            rise_dm_reg <= i_dm;
        end
    end

    // each mask bit gates its own byte lane; a masked lane has its enable low
    always_ff @(negedge i_dqs or posedge i_rst) begin
        if (i_rst) begin
            beat.rise_data <= '0;
            beat.fall_data <= '0;
            beat.rise_be   <= '0;
            beat.fall_be   <= '0;
        end else begin
            beat.rise_data <= rise_dq_reg;
            beat.fall_data <= i_dq;
            beat.rise_be   <= ~rise_dm_reg;
            beat.fall_be   <= ~i_dm;
        end
    end

    property p_lane_indep;
        @(negedge i_dqs) disable iff (i_rst)
        (rise_dm_reg == 2'h1) |=> (beat.rise_be == 2'h2);
    endproperty
    a_lane_indep: assert property (p_lane_indep) else $error("lower mask did not gate only the lower lane");

    property p_fall_mask;
        @(negedge i_dqs) disable iff (i_rst)
        i_dm[1] |=> !beat.fall_be[1];
    endproperty
    a_fall_mask: assert property (p_fall_mask) else $error("masked falling beat left lane enabled");
endmodule : dcd_mask_cap
`default_nettype wire

/* logic/dcd_top.sv */
// Behaviour
// - ACTIVATE takes the row address from the address inputs and opens it in the bank.
// - READ/WRITE take the starting column; address bit 10 requests auto precharge.
// - PRECHARGE closes the addressed bank when bit 10 low, every bank when high.
// - LOAD MODE takes the address inputs as the mode register op-code.
// - the two bank bits pick which of four banks a bank command acts on.
// - during LOAD MODE the bank bits pick one of four mode registers.
// - all command, control and address inputs are sampled on the rising link clock.
// - clock enable registered high enables internal circuitry; low disables it.
// - clock enable low with banks idle: precharge power-down or self refresh; else active.
// - clock enable synchronous except for self refresh exit, which is asynchronous.
// - power-down ignores inputs but clock and enable; self refresh ignores all but enable.
// - commands accepted only when chip select registered low; ignored when high.
// - chip select is decoded ahead of the three-bit command code; high gives deselect whatever the code.
// - a write beat with its mask high is not stored.
// - the mask is sampled on both strobe edges, one value per beat.
// - lower mask covers data 7..0, upper mask covers data 15..8, independently.
// - the command is decoded from row, column strobe, write enable and chip select.
`timescale 1ns/10ps
`default_nettype none
module dcd_top #(
    parameter int ADDR_W    = dcd_pkg::ADDR_W,
    parameter int BA_W      = dcd_pkg::BA_W,
    parameter int NUM_BANKS = dcd_pkg::NUM_BANKS,
    parameter int COL_W     = dcd_pkg::COL_W,
    parameter int DQ_W      = dcd_pkg::DQ_W,
    parameter int DM_W      = dcd_pkg::DM_W
) (
    input  wire logic              i_core_clk,    // core clock, 200 MHz
    input  wire logic              i_rst,         // synchronous reset, active high
    input  wire logic              i_link_clk,    // clock from the controller
    input  wire logic              i_cke,         // clock enable
    input  wire logic              i_cs_n,        // chip select, active low
    input  wire logic              i_ras_n,       // row strobe, active low
    input  wire logic              i_cas_n,       // column strobe, active low
    input  wire logic              i_we_n,        // write enable, active low
    input  wire logic [BA_W-1:0]   i_ba,          // bank address
    input  wire logic [ADDR_W-1:0] i_addr,        // address inputs
    input  wire logic              i_dqs,         // write data strobe
    input  wire logic [DQ_W-1:0]   i_dq,          // write data
    input  wire logic [DM_W-1:0]   i_dm,          // write data mask
    output var  logic              o_cmd_valid,   // one-cycle pulse per accepted command
    output var  dcd_pkg::dcd_cmd_e o_cmd,         // accepted command
    output var  logic [BA_W-1:0]   o_bank,        // bank of the command
    output var  logic [ADDR_W-1:0] o_row,         // row address for activate
    output var  logic [COL_W-1:0]  o_col,         // start column for read/write
    output var  logic              o_auto_pre,    // read/write with auto precharge
    output var  logic              o_pre_all,     // precharge closes all banks
    output var  dcd_pkg::dcd_mr_e  o_mr_sel,      // mode register chosen by load mode
    output var  logic [ADDR_W-1:0] o_mr_opcode,   // op-code for that mode register
    output var  logic [NUM_BANKS-1:0] o_open_banks, // banks with an open row after command
    output var  dcd_pkg::dcd_pwr_e o_pwr_state,   // power state
    output var  logic              o_int_en,      // internal circuitry enabled
    output var  logic [DQ_W-1:0]   o_wr_rise_data,// write beat on rising strobe
    output var  logic [DQ_W-1:0]   o_wr_fall_data,// write beat on falling strobe
    output var  logic [DM_W-1:0]   o_wr_rise_be,  // lane enables of rising beat
    output var  logic [DM_W-1:0]   o_wr_fall_be   // lane enables of falling beat
);
    initial begin
        if (NUM_BANKS != (1 << BA_W)) $error("dcd_top: NUM_BANKS must be 2**BA_W");
        if (ADDR_W <= dcd_pkg::AP_BIT || COL_W > dcd_pkg::AP_BIT) $error("dcd_top: bad address widths");
        if (ADDR_W != dcd_pkg::ADDR_W || BA_W != dcd_pkg::BA_W) $error("dcd_top: event record uses package widths");
    end

    function automatic dcd_pkg::dcd_cmd_e decode_cmd(input logic cs_n, input logic [2:0] code);
        if (cs_n)                          return dcd_pkg::CMD_DESEL;
        else if (code == dcd_pkg::PIN_LMR) return dcd_pkg::CMD_LMR;
        else if (code == dcd_pkg::PIN_REF) return dcd_pkg::CMD_REF;
        else if (code == dcd_pkg::PIN_PRE) return dcd_pkg::CMD_PRE;
        else if (code == dcd_pkg::PIN_ACT) return dcd_pkg::CMD_ACT;
        else if (code == dcd_pkg::PIN_WR)  return dcd_pkg::CMD_WR;
        else if (code == dcd_pkg::PIN_RD)  return dcd_pkg::CMD_RD;
        else                               return dcd_pkg::CMD_NOP;
    endfunction : decode_cmd

    function automatic logic [NUM_BANKS-1:0] bank_bit(input logic [BA_W-1:0] ba);
        return NUM_BANKS'(1) << ba;
    endfunction : bank_bit

    // ---------------- link domain ----------------
    logic                   rst_link;
    logic                   in_cke_reg;
    logic                   cke_prev_reg;
    logic                   in_cs_n_reg;
    logic [2:0]             in_code_reg;
    logic [BA_W-1:0]        in_ba_reg;
    logic [ADDR_W-1:0]      in_addr_reg;
    logic [NUM_BANKS-1:0]   open_reg;
    logic [NUM_BANKS-1:0]   open_next;
    dcd_pkg::dcd_pwr_e      pwr_reg;
    dcd_pkg::dcd_pwr_e      pwr_next;
    dcd_pkg::dcd_event_s    ev_reg;
    logic                   ev_tog_reg;
    logic                   sr_exit_link;

    dcd_sync2 #(.W(1)) u_rst_link (
        .i_clk (i_link_clk),
        .i_d   (i_rst),
        .o_q   (rst_link)
    );

    // pins come from logic timed to the link clock, so one register suffices
    always_ff @(posedge i_link_clk) begin
        in_cke_reg   <= i_cke;
        in_cs_n_reg  <= i_cs_n;
        in_code_reg  <= {i_ras_n, i_cas_n, i_we_n};
        in_ba_reg    <= i_ba;
        in_addr_reg  <= i_addr;
    end

    wire dcd_pkg::dcd_cmd_e cmd_now  = decode_cmd(in_cs_n_reg, in_code_reg);
    wire logic all_idle   = (open_reg == '0);
    wire logic a10        = in_addr_reg[dcd_pkg::AP_BIT];
    wire logic cke_fall   = cke_prev_reg && !in_cke_reg;
    wire logic cmd_real   = (cmd_now != dcd_pkg::CMD_DESEL) && (cmd_now != dcd_pkg::CMD_NOP);
    // only full-power edges with enable high now and before reach the decoder
    wire logic cmd_accept = (pwr_reg == dcd_pkg::PWR_ON) && cke_prev_reg && in_cke_reg && cmd_real;
    wire logic is_act     = cmd_accept && (cmd_now == dcd_pkg::CMD_ACT);
    wire logic is_pre     = cmd_accept && (cmd_now == dcd_pkg::CMD_PRE);
    wire logic is_rdwr    = cmd_accept && ((cmd_now == dcd_pkg::CMD_RD) || (cmd_now == dcd_pkg::CMD_WR));

    // auto precharge is self-timed inside the array; the row counts closed here
    always_comb begin
        open_next = open_reg;
        if (is_act) begin
            open_next = open_reg | bank_bit(in_ba_reg);
        end else if (is_pre && a10) begin
            open_next = '0;
        end else if (is_pre || (is_rdwr && a10)) begin
            open_next = open_reg & ~bank_bit(in_ba_reg);
        end
    end

    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            dcd_pkg::PWR_ON: begin
                if (cke_fall && !in_cs_n_reg && (in_code_reg == dcd_pkg::PIN_REF) && all_idle) begin
                    pwr_next = dcd_pkg::PWR_SREF;
                end else if (cke_fall && all_idle) begin
                    pwr_next = dcd_pkg::PWR_PPD;
                end else if (cke_fall) begin
                    pwr_next = dcd_pkg::PWR_APD;
                end
            end
            dcd_pkg::PWR_PPD, dcd_pkg::PWR_APD: begin
                if (in_cke_reg) pwr_next = dcd_pkg::PWR_ON;
            end
            dcd_pkg::PWR_SREF: begin
                // sampled enable is ignored here; exit comes from the unclocked path
                if (sr_exit_link) pwr_next = dcd_pkg::PWR_ON;
            end
            default: pwr_next = dcd_pkg::PWR_ON;
        endcase
    end

    always_ff @(posedge i_link_clk) begin
        if (rst_link) begin
            cke_prev_reg <= 1'b0;
            open_reg     <= '0;
            pwr_reg      <= dcd_pkg::PWR_ON;
            ev_reg       <= '0;
            ev_tog_reg   <= 1'b0;
        end else begin
            cke_prev_reg <= in_cke_reg;
            open_reg     <= open_next;
            pwr_reg      <= pwr_next;
            if (cmd_accept) begin
                ev_reg     <= '{cmd: cmd_now, ba: in_ba_reg, addr: in_addr_reg, open: open_next};
                ev_tog_reg <= ~ev_tog_reg;
            end
        end
    end

    // one bit per low-power state: every transition flips a single bit
    wire logic [2:0] pwr_lvl = {pwr_reg == dcd_pkg::PWR_SREF, pwr_reg == dcd_pkg::PWR_APD,
                                pwr_reg == dcd_pkg::PWR_PPD};
    wire logic       en_lvl  = in_cke_reg;

    // ---------------- core domain ----------------
    logic [2:0] pwr_sync;
    logic       en_sync;
    logic       cke_sync;
    logic       tog_sync;
    logic       tog_seen_reg;
    logic       sr_exit_reg;

    dcd_sync2 #(.W(6)) u_to_core (
        .i_clk (i_core_clk),
        .i_d   ({pwr_lvl, en_lvl, i_cke, ev_tog_reg}),
        .o_q   ({pwr_sync, en_sync, cke_sync, tog_sync})
    );

    dcd_sync2 #(.W(1)) u_to_link (
        .i_clk (i_link_clk),
        .i_d   (sr_exit_reg),
        .o_q   (sr_exit_link)
    );

    // ev_reg has been stable for two core edges by the time the toggle shows
    wire logic ev_new = tog_sync ^ tog_seen_reg;
    wire dcd_pkg::dcd_event_s ev = ev_reg;
    wire logic ev_a10 = ev.addr[dcd_pkg::AP_BIT];
    wire logic ev_rdwr = (ev.cmd == dcd_pkg::CMD_RD) || (ev.cmd == dcd_pkg::CMD_WR);
    wire dcd_pkg::dcd_pwr_e pwr_core = pwr_sync[2] ? dcd_pkg::PWR_SREF :
                                       pwr_sync[1] ? dcd_pkg::PWR_APD  :
                                       pwr_sync[0] ? dcd_pkg::PWR_PPD  : dcd_pkg::PWR_ON;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tog_seen_reg <= 1'b0;
            sr_exit_reg  <= 1'b0;
            o_cmd_valid  <= 1'b0;
            o_cmd        <= dcd_pkg::CMD_DESEL;
            o_bank       <= '0;
            o_row        <= '0;
            o_col        <= '0;
            o_auto_pre   <= 1'b0;
            o_pre_all    <= 1'b0;
            o_mr_sel     <= dcd_pkg::MR_MAIN;
            o_mr_opcode  <= '0;
            o_open_banks <= '0;
            o_pwr_state  <= dcd_pkg::PWR_ON;
            o_int_en     <= 1'b0;
        end else begin
            tog_seen_reg <= tog_sync;
            sr_exit_reg  <= pwr_sync[2] && cke_sync;
            o_cmd_valid  <= ev_new;
            o_pwr_state  <= pwr_core;
            // in self refresh the link clock may be stopped, so follow the pin
            o_int_en     <= pwr_sync[2] ? cke_sync : en_sync;
            if (ev_new) begin
                o_cmd        <= ev.cmd;
                o_bank       <= ev.ba;
                o_row        <= (ev.cmd == dcd_pkg::CMD_ACT) ? ev.addr : '0;
                o_col        <= ev_rdwr ? ev.addr[COL_W-1:0] : '0;
                o_auto_pre   <= ev_rdwr && ev_a10;
                o_pre_all    <= (ev.cmd == dcd_pkg::CMD_PRE) && ev_a10;
                o_mr_sel     <= dcd_pkg::dcd_mr_e'(ev.ba);
                o_mr_opcode  <= (ev.cmd == dcd_pkg::CMD_LMR) ? ev.addr : '0;
                o_open_banks <= ev.open;
            end
        end
    end

    // ---------------- write mask path ----------------
    dcd_beat_if #(.DQ_W(DQ_W), .DM_W(DM_W)) beat_bus ();

    dcd_mask_cap #(.DQ_W(DQ_W), .DM_W(DM_W)) u_mask (
        .i_dqs (i_dqs),
        .i_rst (rst_link),
        .i_dq  (i_dq),
        .i_dm  (i_dm),
        .beat  (beat_bus.src)
    );

    assign o_wr_rise_data = beat_bus.rise_data;
    assign o_wr_fall_data = beat_bus.fall_data;
    assign o_wr_rise_be   = beat_bus.rise_be;
    assign o_wr_fall_be   = beat_bus.fall_be;

    // ---------------- checks ----------------
    property p_cs_mask;
        @(posedge i_link_clk) disable iff (rst_link)
        in_cs_n_reg |=> (ev_tog_reg == $past(ev_tog_reg));
    endproperty
    a_cs_mask: assert property (p_cs_mask) else $error("command taken with chip select high");

    property p_act_open;
        @(posedge i_link_clk) disable iff (rst_link)
        is_act |=> open_reg[$past(in_ba_reg)] && (ev_reg.cmd == dcd_pkg::CMD_ACT);
    endproperty
    a_act_open: assert property (p_act_open) else $error("activate did not open its bank");

    property p_pre_all;
        @(posedge i_link_clk) disable iff (rst_link)
        (is_pre && a10) |=> (open_reg == '0);
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

    property p_pre_one;
        @(posedge i_link_clk) disable iff (rst_link)
        (is_pre && !a10) |=> (open_reg == ($past(open_reg) & ~bank_bit($past(in_ba_reg))));
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("single precharge touched other banks");

    property p_rdwr_ap;
        @(posedge i_link_clk) disable iff (rst_link)
        (is_rdwr && a10) |=> !open_reg[$past(in_ba_reg)];
    endproperty
    a_rdwr_ap: assert property (p_rdwr_ap) else $error("auto precharge left its bank open");

    property p_sref_hold;
        @(posedge i_link_clk) disable iff (rst_link)
        ((pwr_reg == dcd_pkg::PWR_SREF) && !sr_exit_link) |=> (pwr_reg == dcd_pkg::PWR_SREF);
    endproperty
    a_sref_hold: assert property (p_sref_hold) else $error("self refresh left without the exit path");

    property p_sref_entry;
        @(posedge i_link_clk) disable iff (rst_link)
        ((pwr_reg == dcd_pkg::PWR_ON) && cke_fall && (cmd_now == dcd_pkg::CMD_REF) && all_idle)
            |=> (pwr_reg == dcd_pkg::PWR_SREF);
    endproperty
    a_sref_entry: assert property (p_sref_entry) else $error("self refresh not entered");

    property p_apd_entry;
        @(posedge i_link_clk) disable iff (rst_link)
        ((pwr_reg == dcd_pkg::PWR_ON) && cke_fall && !all_idle) |=> (pwr_reg == dcd_pkg::PWR_APD);
    endproperty
    a_apd_entry: assert property (p_apd_entry) else $error("active power-down not entered");

    property p_pd_ignore;
        @(posedge i_link_clk) disable iff (rst_link)
        ((pwr_reg == dcd_pkg::PWR_PPD) || (pwr_reg == dcd_pkg::PWR_APD) || (pwr_reg == dcd_pkg::PWR_SREF))
            |=> (ev_tog_reg == $past(ev_tog_reg));
    endproperty
    a_pd_ignore: assert property (p_pd_ignore) else $error("command taken while powered down");

    property p_pd_exit;
        @(posedge i_link_clk) disable iff (rst_link)
        ((pwr_reg == dcd_pkg::PWR_PPD) && in_cke_reg) |=> (pwr_reg == dcd_pkg::PWR_ON);
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power-down exit missed");

    property p_lmr_sel;
        @(posedge i_core_clk) disable iff (i_rst)
        (ev_new && (ev.cmd == dcd_pkg::CMD_LMR)) |=> o_cmd_valid && (o_mr_sel == $past(ev.ba))
            && (o_mr_opcode == $past(ev.addr));
    endproperty
    a_lmr_sel: assert property (p_lmr_sel) else $error("mode register load misrouted");

    property p_valid_pulse;
        @(posedge i_core_clk) disable iff (i_rst)
        o_cmd_valid |=> !o_cmd_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("command valid held over two cycles");

    c_sref:  cover property (@(posedge i_link_clk) disable iff (rst_link) pwr_reg == dcd_pkg::PWR_SREF);
    c_apd:   cover property (@(posedge i_link_clk) disable iff (rst_link) pwr_reg == dcd_pkg::PWR_APD);
    c_preal: cover property (@(posedge i_link_clk) disable iff (rst_link) is_pre && a10);
    c_autop: cover property (@(posedge i_core_clk) disable iff (i_rst) o_cmd_valid && o_auto_pre);
endmodule : dcd_top
`default_nettype wire

/* dv/dcd_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dcd_ctrl_model (
    input  wire logic        i_link_clk, // controller clock, pins move just after it
    output var  logic        o_cke,      // clock enable
    output var  logic [3:0]  o_cmd_n,    // {cs_n, ras_n, cas_n, we_n}
    output var  logic [1:0]  o_ba,       // bank address
    output var  logic [12:0] o_addr,     // address inputs
    output var  logic        o_dqs,      // write strobe
    output var  logic [15:0] o_dq,       // write data
    output var  logic [1:0]  o_dm        // write mask
);
    initial begin
        {o_cke, o_dqs, o_cmd_n, o_ba, o_dm} = {2'h0, 4'hF, 2'h0, 2'h0};
        o_addr = 13'h0000;
        o_dq = 16'h0000;
    end
    // enable, command, bank and address pins held for the whole link cycle before their sampling edge
    task automatic issue(input logic c, input logic [3:0] n, input logic [1:0] b, input logic [12:0] a);
        @(posedge i_link_clk);
        o_cke <= c;
        o_cmd_n <= n;
        o_ba <= b;
        o_addr <= a;
    endtask : issue
    // released bank and address lines flip, so a stale value never looks valid
    task automatic idle(input logic c);
        issue(c, 4'h7, ~o_ba, ~o_addr);
    endtask : idle
    // data centred on the rising strobe edge; the falling beat is held 10 ns past its edge, then scrambled
    task automatic beat(input logic [15:0] d0, input logic [1:0] m0, input logic [15:0] d1, input logic [1:0] m1);
        @(posedge i_link_clk);
        o_dq = d0;
        o_dm = m0;
        #20 o_dqs = 1'b1;
        #20 o_dq = d1;
        o_dm = m1;
        #20 o_dqs = 1'b0;
        #10 o_dq = ~d1;
        o_dm = ~m1;
    endtask : beat
endmodule : dcd_ctrl_model
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic              core_clk = 1'b0;
    logic              link_clk = 1'b0;
    logic              rst = 1'b1;
    logic              cke, dqs, cmd_valid, auto_pre, pre_all, int_en;
    logic [3:0]        cmd_n, open_b;
    logic [1:0]        ba, dm, bank, rise_be, fall_be;
    logic [12:0]       addr, row, opcode;
    logic [15:0]       dq, rise_d, fall_d;
    logic [9:0]        col;
    dcd_pkg::dcd_cmd_e cmd;
    dcd_pkg::dcd_pwr_e pwr;
    dcd_pkg::dcd_mr_e  mr_sel;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                pulses = 0;
    always #2.5 core_clk = ~core_clk;
    initial #13.3 forever #40 link_clk = ~link_clk;
    always @(posedge core_clk) if (cmd_valid === 1'b1) pulses <= pulses + 1;
    dcd_top i_dut (
        .i_core_clk(core_clk), .i_rst(rst), .i_link_clk(link_clk), .i_cke(cke),
        .i_cs_n(cmd_n[3]), .i_ras_n(cmd_n[2]), .i_cas_n(cmd_n[1]), .i_we_n(cmd_n[0]),
        .i_ba(ba), .i_addr(addr), .i_dqs(dqs), .i_dq(dq), .i_dm(dm), .o_cmd_valid(cmd_valid),
        .o_cmd(cmd), .o_bank(bank), .o_row(row), .o_col(col), .o_auto_pre(auto_pre),
        .o_pre_all(pre_all), .o_mr_sel(mr_sel), .o_mr_opcode(opcode), .o_open_banks(open_b),
        .o_pwr_state(pwr), .o_int_en(int_en), .o_wr_rise_data(rise_d), .o_wr_fall_data(fall_d),
        .o_wr_rise_be(rise_be), .o_wr_fall_be(fall_be));
    dcd_ctrl_model i_ctrl (.i_link_clk(link_clk), .o_cke(cke), .o_cmd_n(cmd_n), .o_ba(ba),
        .o_addr(addr), .o_dqs(dqs), .o_dq(dq), .o_dm(dm));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string w);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, w, seen, exp);
        end
    endtask : chk
    task automatic hold(input logic c, input int n);
        repeat (n) i_ctrl.idle(c);
    endtask : hold
    // three idle cycles cover the decode edge plus the crossing into the core
    task automatic send(input logic [3:0] n, input logic [1:0] b, input logic [12:0] a, input int np);
        int p0;
        p0 = pulses;
        i_ctrl.issue(1'b1, n, b, a);
        hold(1'b1, 3);
        chk(16'(pulses - p0), 16'(np), "pulses");
    endtask : send
    task automatic t_bank();
        for (int b = 0; b < 4; b++) begin
            send({1'b0, dcd_pkg::PIN_ACT}, 2'(b), 13'h1A5C ^ 13'(b), 1);
            chk({bank, 1'b0, row}, {2'(b), 1'b0, 13'h1A5C ^ 13'(b)}, "act");
            chk(16'(open_b), 16'((2 << b) - 1), "open");
        end
        send({1'b0, dcd_pkg::PIN_RD}, 2'h2, 13'h0155, 1);
        chk({5'h0, auto_pre, col}, 16'h0155, "rd col");
        send({1'b0, dcd_pkg::PIN_WR}, 2'h2, 13'h07AA, 1);
        chk({5'h0, auto_pre, col}, 16'h07AA, "wr col");
        chk(16'({open_b, cmd}), 16'({4'hB, dcd_pkg::CMD_WR}), "wr ap");
        send({1'b0, dcd_pkg::PIN_PRE}, 2'h1, 13'h1BFF, 1);
        chk(16'({pre_all, open_b}), 16'h0009, "pre one");
        send({1'b0, dcd_pkg::PIN_PRE}, 2'h0, 13'h0400, 1);
        chk(16'({pre_all, open_b}), 16'h0010, "pre all");
        for (int m = 0; m < 4; m++) begin
            send({1'b0, dcd_pkg::PIN_LMR}, 2'(m), 13'h0A53 + 13'(m), 1);
            chk({1'b0, mr_sel, opcode}, {1'b0, 2'(m), 13'h0A53 + 13'(m)}, "mode");
        end
        send({1'b1, dcd_pkg::PIN_ACT}, 2'h0, 13'h0000, 0);
        send({1'b0, dcd_pkg::PIN_NOP}, 2'h0, 13'h0000, 0);
        chk(16'(open_b), 16'h0000, "masked");
        $display("bank command test done");
    endtask : t_bank
    task automatic t_power();
        int p0;
        hold(1'b0, 4);
        chk(16'({int_en, pwr}), 16'(dcd_pkg::PWR_PPD), "ppd");
        p0 = pulses;
        i_ctrl.issue(1'b0, {1'b0, dcd_pkg::PIN_ACT}, 2'h0, 13'h0000);
        hold(1'b0, 3);
        chk({open_b, 12'(pulses - p0)}, 16'h0000, "pd ignore");
        hold(1'b1, 4);
        chk(16'({int_en, pwr}), 16'h0004, "pd exit");
        send({1'b0, dcd_pkg::PIN_ACT}, 2'h3, 13'h0001, 1);
        hold(1'b0, 4);
        chk(16'(pwr), 16'(dcd_pkg::PWR_APD), "apd");
        hold(1'b1, 3);
        send({1'b0, dcd_pkg::PIN_PRE}, 2'h3, 13'h0400, 1);
        i_ctrl.issue(1'b0, {1'b0, dcd_pkg::PIN_REF}, 2'h0, 13'h0000);
        hold(1'b0, 3);
        chk(16'({int_en, pwr}), 16'(dcd_pkg::PWR_SREF), "sref");
        hold(1'b1, 5);
        chk(16'({int_en, pwr}), 16'h0004, "sref exit");
        $display("power test done");
    endtask : t_power
    task automatic t_beats();
        for (int m = 0; m < 4; m++) begin
            i_ctrl.beat(16'hA5C3 + 16'(m), 2'(m), 16'h3C5A - 16'(m), 2'(3 - m));
            #5;
            chk(rise_d, 16'hA5C3 + 16'(m), "rise data");
            chk(fall_d, 16'h3C5A - 16'(m), "fall data");
            chk(16'({rise_be, fall_be}), 16'({~2'(m), 2'(m)}), "lanes");
        end
        $display("mask test done");
    endtask : t_beats
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        // reset spans several link edges so the link side sees it too
        repeat (16) @(posedge link_clk);
        rst <= 1'b0;
        hold(1'b1, 5);
        t_bank();
        t_power();
        t_beats();
        complete_run();
    end
    // the tests need some 9.3 us; about thirty-four times that means a hang
    initial begin
        #320000;
        bad_count++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
